// *** dv/clock_source_model.sv ***
`timescale 1ns/100ps
module clock_source_model
  import clock_control_pkg::*;
#(
  parameter int unsigned HALF     = 2,
  parameter int unsigned EXT_HALF = 3
) (
  input  wire logic    pclk,
  output clock_src_type osc128_clock,
  output clock_src_type rc_osc_clock,
  output logic          external_clock_input_pin
);
  int unsigned cnt      = 0;
  int unsigned ext_cnt  = 0;
  logic        lvl      = 1'b0;
  logic        tck      = 1'b0;
  logic        rc_lvl   = 1'b0;
  logic        ext_lvl  = 1'b0;

  // Slow oscillator runs free, also through reset; tick lands with the rising level
  always_ff @(posedge pclk) begin
    tck <= (cnt == HALF - 1) && !lvl;
    if (cnt == HALF - 1) begin
      cnt <= 0;
      lvl <= ~lvl;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // Fast oscillator and external pin at fixed rates, no step in frequency
  always_ff @(posedge pclk) begin
    rc_lvl <= ~rc_lvl;
    if (ext_cnt == EXT_HALF - 1) begin
      ext_cnt <= 0;
      ext_lvl <= ~ext_lvl;
    end else begin
      ext_cnt <= ext_cnt + 1;
    end
  end

  // Drive the source structs
  assign osc128_clock             = '{tick: tck, level: lvl};
  assign rc_osc_clock             = '{tick: rc_lvl, level: rc_lvl};
  assign external_clock_input_pin = ext_lvl;
endmodule

// *** dv/tb_system_clock_control.sv ***
`timescale 1ns/100ps
module tb_system_clock_control;
  import clock_control_pkg::*;
  localparam int TP = 4;
  localparam int EP = 6;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        src_fuses;
  logic [1:0]        sut_fuses;
  logic              out_fuse, div8_fuse, ext_pin, tosc_pin, xtal_tick, tosc_req;
  logic              sleep_req, wake_ev, gpio_out, gpio_oe, err;
  logic              tosc_en, timer_tick, sys_level, clk_pin, clk_oe, running;
  clock_src_type     osc128, rc_osc;
  domain_clocks_type doms;
  int                failures, check_count, model_sel, cyc;
  int                ivl[$];

  clock_source_model clock_source_model_i (.pclk(pclk), .osc128_clock(osc128), .rc_osc_clock(rc_osc),
    .external_clock_input_pin(ext_pin));

  system_clock_control #(.INT_FAST_CYCLES(20), .INT_SLOW_CYCLES(20), .EXT_FAST_CYCLES(20),
    .EXT_SLOW_CYCLES(20)) system_clock_control_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .clock_source_select_fuses(src_fuses), .startup_delay_fuses(sut_fuses), .clock_out_fuse(out_fuse),
    .divide_by_eight_fuse(div8_fuse), .osc128_clock(osc128), .rc_osc_clock(rc_osc),
    .external_clock_input_pin(ext_pin), .timer_osc_input_pin(tosc_pin), .timer_crystal_tick(xtal_tick),
    .timer_osc_request(tosc_req), .sleep_request(sleep_req), .wake_event(wake_ev), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .timer_osc_enable(tosc_en), .timer_clock_tick(timer_tick), .domain_clocks(doms),
    .system_clock_level(sys_level), .clock_out_pin(clk_pin), .clock_out_pin_oe(clk_oe),
    .clocks_running(running));

  // Master clock, 50 ns
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; result taken at the edge where pready is high
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task set_sel(input logic [31:0] v);
    apb(CDC_ADDR, 1'b1, 32'(UNLOCK_WORD));
    apb(CDC_ADDR, 1'b1, v);
    model_sel = int'(v[3:0]);
  endtask

  // Expected core period in pclk cycles from the select code
  function int per(input int s);
    return TP << ((s > 8) ? 8 : s);
  endfunction

  // Record intervals between core pulses; watch clock pin and domains meanwhile
  task measure(input int n);
    int c;
    c = 0;
    ivl = {};
    while (ivl.size() < n) begin
      @(posedge pclk); #1;
      c++;
      check({clk_oe, clk_pin}, {1'b1, sys_level});
      check(doms, {4{doms.core}});
      if (doms.core === 1'b1) begin
        ivl.push_back(c);
        c = 0;
      end
    end
  endtask

  // Count cycles until the clocks run, bounded
  task wait_run;
    cyc = 0;
    do begin
      @(posedge pclk); #1;
      cyc++;
    end while (running !== 1'b1 && cyc < 3000);
  endtask

  task end_sim;
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    #(50 * 40000);
    failures++;
    end_sim();
  end

  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    src_fuses = SRC_INT128; sut_fuses = SUT_FAST; out_fuse = 1'b1; div8_fuse = 1'b1;
    tosc_pin = 1'b0; xtal_tick = 1'b0; tosc_req = 1'b0; sleep_req = 1'b0; wake_ev = 1'b0;
    gpio_out = 1'b0; gpio_oe = 1'b0; failures = 0; check_count = 0; model_sel = 3;
    void'($urandom(32'h91ad0590));
    repeat (2) @(posedge pclk);
    #1 check({clk_oe, clk_pin}, {1'b1, osc128.level});
    @(posedge pclk);
    presetn <= 1'b1;
    wait_run();
    check(cyc >= 13 * TP + 20 && cyc <= 14 * TP + 26, 1);
    rd_chk(CDC_ADDR, 32'h3);
    rd_chk(STATUS_ADDR, 32'h31);
    apb(CDC_ADDR, 1'b1, 32'h5);
    rd_chk(CDC_ADDR, 32'h3);
    apb(CDC_ADDR, 1'b1, 32'h81);
    apb(CDC_ADDR, 1'b1, 32'h2);
    rd_chk(CDC_ADDR, 32'h3);
    apb(CDC_ADDR, 1'b1, 32'h80);
    rd_chk(CDC_ADDR, 32'h83);
    repeat (2 * per(3)) @(posedge pclk);
    apb(CDC_ADDR, 1'b1, 32'h80);
    rd_chk(CDC_ADDR, 32'h83);
    repeat (2 * per(3)) @(posedge pclk);
    rd_chk(CDC_ADDR, 32'h3);
    apb(CDC_ADDR, 1'b1, 32'h2);
    rd_chk(CDC_ADDR, 32'h3);
    for (int s = 0; s <= 9; s++) begin
      int code, old;
      code = (s == 9) ? 9 + int'($urandom % 7) : s;
      old = model_sel;
      set_sel(32'(code));
      measure(4);
      for (int k = 1; k < 4; k++)
        check(ivl[k] >= ((per(old) < per(code)) ? per(old) : per(code)), 1);
      check(ivl[3], per(code));
      rd_chk(CDC_ADDR, 32'(code));
      rd_chk(STATUS_ADDR, 32'((code << 4) | 1));
    end
    apb(12'h010, 1'b0, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(ASYNC_ADDR, 1'b1, 32'h1);
    rd_chk(ASYNC_ADDR, 32'h1);
    tosc_req <= 1'b1;
    out_fuse <= 1'b0;
    gpio_out <= 1'($urandom);
    gpio_oe <= 1'($urandom);
    @(posedge pclk); #1;
    check(tosc_en, 1'b0);
    check({clk_oe, clk_pin}, {gpio_oe, gpio_out});
    @(posedge pclk);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge pclk); #1;
    check(running, 1'b0);
    @(posedge pclk);
    wake_ev <= 1'b1;
    @(posedge pclk);
    wake_ev <= 1'b0;
    wait_run();
    check(cyc >= 5 * TP - 1 && cyc <= 6 * TP + 4, 1);
    // Mid-run resets: external pin, then RC oscillator with the timer clock
    for (int k = 0; k < 2; k++) begin
      int p;
      p = k ? 2 : EP;
      @(posedge pclk);
      presetn <= 1'b0;
      src_fuses <= k ? SRC_RC : SRC_EXT;
      sut_fuses <= SUT_CK_ONLY;
      div8_fuse <= 1'b0;
      out_fuse <= 1'b1;
      repeat (2) @(posedge pclk); #1;
      check({clk_oe, clk_pin}, {1'b1, k ? rc_osc.level : ext_pin});
      @(posedge pclk);
      presetn <= 1'b1;
      wait_run();
      check(cyc >= 13 * p && cyc <= 15 * p, 1);
      rd_chk(CDC_ADDR, 32'h0);
      measure(3);
      check(ivl[2], p);
      if (k) begin
        @(posedge pclk);
        xtal_tick <= 1'b1;
        #1 check({tosc_en, timer_tick}, 2'b11);
        apb(ASYNC_ADDR, 1'b1, 32'h1);
        tosc_pin <= 1'b1;
        #1 check(timer_tick, 1'b1);
        @(posedge pclk); #1;
        check(timer_tick, 1'b0);
      end
    end
    end_sim();
  end

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask
endmodule

// *** logic/clock_control_pkg.sv ***
package clock_control_pkg;

  // Master clock
  localparam int unsigned PCLK_HZ        = 20_000_000;
  localparam int unsigned CYCLES_PER_US  = PCLK_HZ / 1_000_000;

  // Clock source select codes
  localparam logic [3:0] SRC_EXT         = 4'h0;
  localparam logic [3:0] SRC_RC          = 4'h2;
  localparam logic [3:0] SRC_INT128      = 4'h3;

  // Start-up delay codes
  localparam logic [1:0] SUT_CK_ONLY     = 2'h0;
  localparam logic [1:0] SUT_FAST        = 2'h1;
  localparam logic [1:0] SUT_SLOW        = 2'h2;

  // Start-up counts in source clocks
  localparam int unsigned RESET_CK       = 14;
  localparam int unsigned WAKE_CK        = 6;

  // Additional reset delays in microseconds and in pclk cycles
  localparam int unsigned INT_FAST_US    = 4000;
  localparam int unsigned INT_SLOW_US    = 64000;
  localparam int unsigned EXT_FAST_US    = 4100;
  localparam int unsigned EXT_SLOW_US    = 65000;
  localparam int unsigned INT_FAST_CYC   = INT_FAST_US * CYCLES_PER_US;
  localparam int unsigned INT_SLOW_CYC   = INT_SLOW_US * CYCLES_PER_US;
  localparam int unsigned EXT_FAST_CYC   = EXT_FAST_US * CYCLES_PER_US;
  localparam int unsigned EXT_SLOW_CYC   = EXT_SLOW_US * CYCLES_PER_US;

  // Divider change window in core clock cycles
  localparam int unsigned UNLOCK_CYCLES  = 4;
  localparam logic [7:0]  UNLOCK_WORD    = 8'h80;

  // Register indices; byte address is four times the index
  localparam logic [6:0]  CDC_INDEX      = 7'h61;
  localparam logic [6:0]  ASYNC_INDEX    = 7'h70;
  localparam logic [6:0]  STATUS_INDEX   = 7'h71;
  localparam logic [11:0] CDC_ADDR       = {3'h0, CDC_INDEX, 2'h0};
  localparam logic [11:0] ASYNC_ADDR     = {3'h0, ASYNC_INDEX, 2'h0};
  localparam logic [11:0] STATUS_ADDR    = {3'h0, STATUS_INDEX, 2'h0};

  // Field positions
  localparam int unsigned UNLOCK_BIT     = 7;
  localparam int unsigned TIMER_EXT_BIT  = 0;
  localparam int unsigned READY_BIT      = 0;
  localparam int unsigned ACT_SEL_LSB    = 4;

  // Divider select values
  localparam logic [3:0] SEL_DIV1        = 4'h0;
  localparam logic [3:0] SEL_DIV8        = 4'h3;
  localparam logic [3:0] SEL_MAX         = 4'h8;

  typedef enum logic [2:0] {ST_RESET_CK, ST_RESET_TIME, ST_RUN, ST_SLEEP, ST_WAKE} startup_state_type;

  // A clock source seen from pclk: its level and a one-cycle rising-edge pulse
  typedef struct packed {
    logic tick;
    logic level;
  } clock_src_type;

  // Enable pulses for the divided clock domains
  typedef struct packed {
    logic io;
    logic converter;
    logic core;
    logic program_memory;
  } domain_clocks_type;

endpackage

// *** logic/clock_prescaler_divider.sv ***
`timescale 1ns/100ps
module clock_prescaler_divider
  import clock_control_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire clock_src_type src,
  input  wire logic [3:0]    sel,
  output logic               tick,
  output logic               level,
  output logic [3:0]         active_sel
);

  logic [3:0]       cur_sel_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] last_cnt;
  logic [CNT_W:0]   period;

  // Period in source ticks; reserved codes divide by the largest factor
  always_comb begin
    period = (cur_sel_r > SEL_MAX) ? ({{CNT_W{1'b0}}, 1'b1} << SEL_MAX) : ({{CNT_W{1'b0}}, 1'b1} << cur_sel_r);
    last_cnt = CNT_W'(period - 1'b1);
  end

  // Ripple count of the undivided source; a new setting is taken only at a period boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= '0;
      cur_sel_r <= SEL_DIV1;
    end else if (src.tick) begin
      if (cnt_r == last_cnt) begin
        cnt_r     <= '0;
        cur_sel_r <= sel;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // Divided clock: high for the first half of each period
  assign tick       = src.tick && (cnt_r == last_cnt);
  assign level      = (cur_sel_r == SEL_DIV1) ? src.level : ({1'b0, cnt_r} < (period >> 1));
  assign active_sel = cur_sel_r;

  // Setting changes only on the edge that closes a period
  a_sel_at_boundary: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(cur_sel_r) |-> $past(tick))
    else $error("divider setting changed inside a period");

  // A full period of the active setting separates two divided ticks
  a_period_length: assert property (@(posedge pclk) disable iff (!presetn)
    (src.tick && cnt_r == '0 && cur_sel_r != SEL_DIV1) |-> !tick)
    else $error("divided tick came early");

endmodule

// *** logic/system_clock_control.sv ***
`timescale 1ns/100ps
// Behaviour
// - Fuse code 0011 selects 128kHz oscillator
// - 128kHz: wake 6 CK, reset delays
// - Fuse code 0000 selects external clock pin
// - External: wake 6 CK, reset delays
// - Timer oscillator only with RC source
// - Timer external clock bit selects pin clock
// - Clock out fuse drives pin, even reset
// - Clock pin carries the divided clock
// - Divider feeds all four clock domains
// - Setting changes are glitch free
// - New rate after one old period
// - Ripple counter on source, state unreadable
// - Select accepted only within four cycles
// - Unlock bit times out, no extension
// - Select codes divide by powers of two
// - Reset select from divide-by-eight fuse
module system_clock_control
  import clock_control_pkg::*;
#(
  parameter int unsigned INT_FAST_CYCLES = INT_FAST_CYC,
  parameter int unsigned INT_SLOW_CYCLES = INT_SLOW_CYC,
  parameter int unsigned EXT_FAST_CYCLES = EXT_FAST_CYC,
  parameter int unsigned EXT_SLOW_CYCLES = EXT_SLOW_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic [3:0]        clock_source_select_fuses,
  input  wire logic [1:0]        startup_delay_fuses,
  input  wire logic              clock_out_fuse,
  input  wire logic              divide_by_eight_fuse,
  input  wire clock_src_type     osc128_clock,
  input  wire clock_src_type     rc_osc_clock,
  input  wire logic              external_clock_input_pin,
  input  wire logic              timer_osc_input_pin,
  input  wire logic              timer_crystal_tick,
  input  wire logic              timer_osc_request,
  input  wire logic              sleep_request,
  input  wire logic              wake_event,
  input  wire logic              gpio_out,
  input  wire logic              gpio_oe,
  output logic                   timer_osc_enable,
  output logic                   timer_clock_tick,
  output domain_clocks_type      domain_clocks,
  output logic                   system_clock_level,
  output logic                   clock_out_pin,
  output logic                   clock_out_pin_oe,
  output logic                   clocks_running
);

  clock_src_type     ext_src;
  clock_src_type     src;
  startup_state_type state_r;
  logic              ext_q_r;
  logic              tpin_q_r;
  logic              init_pending_r;
  logic [3:0]        sel_r;
  logic              unlock_r;
  logic [2:0]        unlock_cnt_r;
  logic              timer_ext_r;
  logic [31:0]       wait_r;
  logic [31:0]       time_limit;
  logic              sys_tick;
  logic              sys_level;
  logic [3:0]        active_sel;
  logic              wr_cdc;
  logic              wr_unlock;
  logic              wr_select;
  logic              mapped;
  logic [31:0]       rd_mux;

  // Edge detect on the clock pins, taken as synchronous to pclk
  // History held high in reset, so a pin already high at release gives no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q_r  <= 1'b1;
      tpin_q_r <= 1'b1;
    end else begin
      ext_q_r  <= external_clock_input_pin;
      tpin_q_r <= timer_osc_input_pin;
    end
  end

  assign ext_src.level = external_clock_input_pin;
  assign ext_src.tick  = external_clock_input_pin && !ext_q_r;

  // Source selection by fuse; unsupported codes fall back to the external pin
  always_comb begin
    if (clock_source_select_fuses == SRC_INT128) begin
      src = osc128_clock;
    end else if (clock_source_select_fuses == SRC_RC) begin
      src = rc_osc_clock;
    end else begin
      src = ext_src;
    end
  end

  // Timer oscillator shares the crystal pins, so it runs only beside the RC source
  assign timer_osc_enable = timer_osc_request && (clock_source_select_fuses == SRC_RC);
  assign timer_clock_tick = timer_osc_enable &&
                            (timer_ext_r ? (timer_osc_input_pin && !tpin_q_r) : timer_crystal_tick);

  // Additional reset delay chosen by source and start-up fuses
  always_comb begin
    time_limit = 32'h0;
    if (startup_delay_fuses == SUT_FAST) begin
      time_limit = (clock_source_select_fuses == SRC_INT128) ? INT_FAST_CYCLES : EXT_FAST_CYCLES;
    end else if (startup_delay_fuses == SUT_SLOW) begin
      time_limit = (clock_source_select_fuses == SRC_INT128) ? INT_SLOW_CYCLES : EXT_SLOW_CYCLES;
    end
  end

  // Start-up and wake sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RESET_CK;
      wait_r  <= 32'h0;
    end else begin
      case (state_r)
        ST_RESET_CK: begin
          if (src.tick) begin
            if (wait_r == RESET_CK - 1) begin
              wait_r  <= 32'h0;
              state_r <= (time_limit == 32'h0) ? ST_RUN : ST_RESET_TIME;
            end else begin
              wait_r <= wait_r + 32'h1;
            end
          end
        end
        ST_RESET_TIME: begin
          if (wait_r == time_limit - 32'h1) begin
            wait_r  <= 32'h0;
            state_r <= ST_RUN;
          end else begin
            wait_r <= wait_r + 32'h1;
          end
        end
        ST_RUN: begin
          if (sleep_request) begin
            state_r <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_event) begin
            wait_r  <= 32'h0;
            state_r <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (src.tick) begin
            if (wait_r == WAKE_CK - 1) begin
              wait_r  <= 32'h0;
              state_r <= ST_RUN;
            end else begin
              wait_r <= wait_r + 32'h1;
            end
          end
        end
        default: begin
          state_r <= ST_RESET_CK;
        end
      endcase
    end
  end

  assign clocks_running = (state_r == ST_RUN);

  // APB decode; every access completes in one access cycle
  assign wr_cdc    = psel && penable && pwrite && (paddr == CDC_ADDR);
  assign wr_unlock = wr_cdc && (pwdata[7:0] == UNLOCK_WORD) && !unlock_r;
  assign wr_select = wr_cdc && !pwdata[UNLOCK_BIT] && unlock_r;
  assign mapped    = (paddr == CDC_ADDR) || (paddr == ASYNC_ADDR) || (paddr == STATUS_ADDR);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;

  // Divider select: cleared at reset, loaded from the fuse in the first cycle after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_pending_r <= 1'b1;
      sel_r          <= SEL_DIV1;
    end else if (init_pending_r) begin
      init_pending_r <= 1'b0;
      sel_r          <= divide_by_eight_fuse ? SEL_DIV8 : SEL_DIV1;
    end else if (wr_select) begin
      sel_r <= pwdata[3:0];
    end
  end

  // Unlock bit and its four-cycle window counted in core clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_r     <= 1'b0;
      unlock_cnt_r <= 3'h0;
    end else if (wr_unlock) begin
      unlock_r     <= 1'b1;
      unlock_cnt_r <= 3'h0;
    end else if (unlock_r) begin
      if (wr_select) begin
        unlock_r <= 1'b0;
      end else if (sys_tick) begin
        if (unlock_cnt_r == 3'(UNLOCK_CYCLES - 1)) begin
          unlock_r <= 1'b0;
        end else begin
          unlock_cnt_r <= unlock_cnt_r + 3'h1;
        end
      end
    end
  end

  // Timer external clock enable in the asynchronous timer status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ext_r <= 1'b0;
    end else if (psel && penable && pwrite && paddr == ASYNC_ADDR) begin
      timer_ext_r <= pwdata[TIMER_EXT_BIT];
    end
  end

  // Read mux; the divider count itself is not visible
  always_comb begin
    rd_mux = 32'h0;
    if (paddr == CDC_ADDR) begin
      rd_mux[UNLOCK_BIT] = unlock_r;
      rd_mux[3:0]        = sel_r;
    end else if (paddr == ASYNC_ADDR) begin
      rd_mux[TIMER_EXT_BIT] = timer_ext_r;
    end else if (paddr == STATUS_ADDR) begin
      rd_mux[READY_BIT]                 = clocks_running;
      rd_mux[ACT_SEL_LSB +: 4]          = active_sel;
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Prescaler on the undivided source
  clock_prescaler_divider #(
    .CNT_W (8)
  ) u_divider (
    .pclk       (pclk),
    .presetn    (presetn),
    .src        (src),
    .sel        (sel_r),
    .tick       (sys_tick),
    .level      (sys_level),
    .active_sel (active_sel)
  );

  // One divided clock for every domain, stopped outside run
  assign domain_clocks.io             = sys_tick && clocks_running;
  assign domain_clocks.converter      = sys_tick && clocks_running;
  assign domain_clocks.core           = sys_tick && clocks_running;
  assign domain_clocks.program_memory = sys_tick && clocks_running;
  assign system_clock_level           = sys_level;

  // Clock output pin overrides the port function, and carries the source during reset
  assign clock_out_pin    = clock_out_fuse ? (presetn ? sys_level : src.level) : gpio_out;
  assign clock_out_pin_oe = clock_out_fuse ? 1'b1 : gpio_oe;

  sequence s_unlock;
    wr_unlock;
  endsequence

  sequence s_select;
    wr_cdc && !pwdata[UNLOCK_BIT];
  endsequence

  a_reset_strap: assert property (@(posedge pclk) disable iff (!presetn)
    init_pending_r |=> sel_r == ($past(divide_by_eight_fuse) ? SEL_DIV8 : SEL_DIV1))
    else $error("select not loaded from fuse after reset");

  a_change_sequence: assert property (@(posedge pclk) disable iff (!presetn)
    s_unlock ##[2:3] s_select |=> sel_r == $past(pwdata[3:0]) && !unlock_r)
    else $error("select not accepted right after unlock");

  a_select_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cdc && !unlock_r && !init_pending_r) |=> sel_r == $past(sel_r))
    else $error("select changed without unlock");

  a_unlock_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    (unlock_r && sys_tick && unlock_cnt_r == 3'(UNLOCK_CYCLES - 1) && !wr_unlock) |=> !unlock_r)
    else $error("unlock window not closed");

  a_unlock_no_extend: assert property (@(posedge pclk) disable iff (!presetn)
    (unlock_r && wr_cdc && pwdata[7:0] == UNLOCK_WORD) |=> unlock_cnt_r >= $past(unlock_cnt_r))
    else $error("rewrite extended unlock window");

  a_clock_out_pin: assert property (@(posedge pclk) disable iff (!presetn)
    clock_out_fuse |-> clock_out_pin_oe && clock_out_pin == sys_level)
    else $error("clock out pin not driven with divided clock");

  a_timer_gate: assert property (@(posedge pclk) disable iff (!presetn)
    timer_clock_tick |-> clock_source_select_fuses == SRC_RC)
    else $error("timer clock outside RC source");

  a_source_select: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_source_select_fuses == SRC_EXT) |-> src.tick == (external_clock_input_pin && !ext_q_r))
    else $error("external source not selected");

  a_wake_count: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_WAKE && src.tick && wait_r == WAKE_CK - 1) |=> state_r == ST_RUN)
    else $error("wake delay wrong");

  a_domain_tick: assert property (@(posedge pclk) disable iff (!presetn)
    domain_clocks.core |-> domain_clocks.io && domain_clocks.converter && sys_tick)
    else $error("domain clocks disagree");

endmodule
